// >>> common/ee_pkg.sv
// Purpose: shared constants and types for the two-wire eeprom ends
// Assumes: 25 MHz system clock on both ends
`default_nettype none
package ee_pkg;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 8192;
  localparam int FIFO_DEPTH = 32;
  localparam int BYTE_BITS = 8;
  // arbitrary type identifier value
  localparam logic [3:0] TYPE_ID = 4'h5;
  localparam longint CLK_HZ = 25000000;
  localparam longint PROG_TIME_MS = 5;
  // longest time, so rounded down
  localparam int PROG_CYCLES_DFLT = int'((CLK_HZ * PROG_TIME_MS) / 1000);
  // quarter of one bus bit period in system clocks
  localparam int QUARTER_CYCLES = 4;
  typedef enum logic [1:0] {OP_WRITE, OP_CUR_READ, OP_RAND_READ, OP_POLL} ee_op_type;
endpackage
`default_nettype wire

// >>> common/ee_link_if.sv
// Purpose: two-wire link between master end and eeprom end
// Assumes: open-drain data, clock driven by master only
// Notes: wire level is worked out here from the enables
`default_nettype none
interface ee_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;
  // pull-up wins unless a driver pulls low
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));
  modport host (output scl, output host_sda_out, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
endinterface
`default_nettype wire

// >>> design/ee_host_end.sv
// Purpose: bus master end with write-data fifo
// Assumes: clk 25 MHz, the eeprom end on the same link
// Notes: master makes the bus clock by dividing clk
`default_nettype none
module ee_fifo
  import ee_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic push, pop;
  assign in_ready = (wptr_reg[PW] == rptr_reg[PW]) || (wptr_reg[PW-1:0] != rptr_reg[PW-1:0]);
  assign out_valid = wptr_reg != rptr_reg;
  assign out_data = mem_reg[rptr_reg[PW-1:0]];
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else if (ce)
    begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
  end
  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem_reg[wptr_reg[PW-1:0]] <= in_data;
  end
endmodule

module ee_host_end
  import ee_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  ee_link_if.host link,
  input wire logic op_valid,
  output logic op_ready,
  input wire ee_op_type op_kind,
  input wire logic [2:0] op_sel,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [7:0] op_len,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic op_done,
  output logic op_nack
);
  typedef enum {H_IDLE, H_START, H_BYTE, H_STOP} ee_hstate_type;
  typedef enum {S_DEVW, S_AH, S_AL, S_WDATA, S_DEVR, S_RDATA} ee_step_type;
  ee_hstate_type state_reg, state_next;
  ee_step_type step_reg, step_next;
  ee_op_type kind_reg, kind_next;
  logic [2:0] sel_reg, sel_next, q_reg, q_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shf_reg, shf_next, cnt_reg, cnt_next, rd_data_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic scl_reg, scl_next, sda_reg, sda_next, ack_reg, ack_next;
  logic rd_valid_next, done_next, nack_next, s1_reg, sda_s;
  logic tick, reading, need, f_valid, f_pop;
  logic [7:0] f_data;

  function automatic logic [7:0] dev_byte(input logic [2:0] sel, input logic rd);
    dev_byte = {TYPE_ID, sel, rd};
  endfunction

  ee_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .rstn(rstn), .ce(ce),
    .in_data(wr_data), .in_valid(wr_valid), .in_ready(wr_ready),
    .out_data(f_data), .out_valid(f_valid), .out_ready(f_pop)
  );

  assign op_ready = state_reg == H_IDLE;
  assign link.scl = scl_reg;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = !sda_reg;

  always_comb
  begin
    state_next = state_reg;
    step_next = step_reg;
    kind_next = kind_reg;
    sel_next = sel_reg;
    ph_next = ph_reg;
    bit_next = bit_reg;
    shf_next = shf_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    ack_next = ack_reg;
    rd_data_next = rd_data;
    rd_valid_next = 1'b0;
    done_next = 1'b0;
    nack_next = 1'b0;
    f_pop = 1'b0;
    tick = q_reg == 3'(QUARTER_CYCLES - 1);
    q_next = (state_reg == H_IDLE || tick) ? 3'h0 : q_reg + 3'h1;
    reading = step_reg == S_RDATA;
    need = (step_reg == S_AL && kind_reg == OP_WRITE && cnt_reg != 8'h00)
        || (step_reg == S_WDATA && cnt_reg != 8'h01);
    case (state_reg)
      H_IDLE:
      begin
        if (op_valid)
        begin
          kind_next = op_kind;
          sel_next = op_sel;
          addr_next = op_addr;
          cnt_next = op_len;
          ph_next = 2'h0;
          step_next = (op_kind == OP_CUR_READ) ? S_DEVR : S_DEVW;
          state_next = H_START;
        end
      end
      H_START:
      begin
        if (tick)
        begin
          ph_next = ph_reg + 2'h1;
          // release data before raising clock so no false stop
          case (ph_reg)
            2'h0: sda_next = 1'b1;
            2'h1: scl_next = 1'b1;
            2'h2: sda_next = 1'b0;
            default:
            begin
              scl_next = 1'b0;
              bit_next = 4'h0;
              shf_next = dev_byte(sel_reg, step_reg == S_DEVR);
              state_next = H_BYTE;
            end
          endcase
        end
      end
      H_BYTE:
      begin
        if (tick)
        begin
          ph_next = ph_reg + 2'h1;
          case (ph_reg)
            2'h0:
              if (bit_reg < 4'(BYTE_BITS))
                sda_next = reading ? 1'b1 : shf_reg[7];
              else
                sda_next = reading ? (cnt_reg == 8'h01) : 1'b1;
            2'h1: scl_next = 1'b1;
            2'h2:
              if (bit_reg < 4'(BYTE_BITS))
                shf_next = {shf_reg[6:0], reading ? sda_s : 1'b0};
              else
                ack_next = sda_s;
            default:
            begin
              scl_next = 1'b0;
              if (bit_reg < 4'(BYTE_BITS))
                bit_next = bit_reg + 4'h1;
              else if (reading)
              begin
                rd_data_next = shf_reg;
                rd_valid_next = 1'b1;
                cnt_next = cnt_reg - 8'h01;
                bit_next = 4'h0;
                if (cnt_reg == 8'h01)
                  state_next = H_STOP;
              end
              else if (ack_reg)
              begin
                nack_next = 1'b1;
                state_next = H_STOP;
              end
              else if (need)
              begin
                // stall with the bus clock low until data arrives
                if (!f_valid)
                  ph_next = ph_reg;
                else
                begin
                  f_pop = 1'b1;
                  shf_next = f_data;
                  bit_next = 4'h0;
                  if (step_reg == S_WDATA)
                    cnt_next = cnt_reg - 8'h01;
                  step_next = S_WDATA;
                end
              end
              else
              begin
                bit_next = 4'h0;
                case (step_reg)
                  S_DEVW:
                    if (kind_reg == OP_POLL)
                      state_next = H_STOP;
                    else
                    begin
                      step_next = S_AH;
                      shf_next = {3'h0, addr_reg[ADDR_W-1:8]};
                    end
                  S_AH:
                  begin
                    step_next = S_AL;
                    shf_next = addr_reg[7:0];
                  end
                  S_AL:
                    if (kind_reg == OP_RAND_READ)
                    begin
                      ph_next = 2'h0;
                      step_next = S_DEVR;
                      state_next = H_START;
                    end
                    else
                      state_next = H_STOP;
                  S_DEVR: step_next = S_RDATA;
                  default: state_next = H_STOP;
                endcase
              end
            end
          endcase
        end
      end
      H_STOP:
      begin
        if (tick)
        begin
          ph_next = ph_reg + 2'h1;
          case (ph_reg)
            2'h0: sda_next = 1'b0;
            2'h1: scl_next = 1'b1;
            2'h2: sda_next = 1'b1;
            default:
            begin
              done_next = 1'b1;
              state_next = H_IDLE;
            end
          endcase
        end
      end
      default: state_next = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= H_IDLE;
      step_reg <= S_DEVW;
      kind_reg <= OP_WRITE;
      sel_reg <= 3'h0;
      q_reg <= 3'h0;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      shf_reg <= 8'h00;
      cnt_reg <= 8'h00;
      addr_reg <= '0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      ack_reg <= 1'b1;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      op_done <= 1'b0;
      op_nack <= 1'b0;
      s1_reg <= 1'b1;
      sda_s <= 1'b1;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      step_reg <= step_next;
      kind_reg <= kind_next;
      sel_reg <= sel_next;
      q_reg <= q_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      shf_reg <= shf_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      ack_reg <= ack_next;
      rd_data <= rd_data_next;
      rd_valid <= rd_valid_next;
      op_done <= done_next;
      op_nack <= nack_next;
      s1_reg <= link.sda;
      sda_s <= s1_reg;
    end
  end
endmodule
`default_nettype wire

// >>> design/ee_dev_end.sv
// Purpose: serial eeprom protocol engine, 8192 bytes
// Assumes: bus clock and data sampled by clk, well below clk rate
// Notes: array and page buffer are flip-flops, contents not reset
`default_nettype none
module ee_dev_end
  import ee_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DFLT
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  ee_link_if.dev link,
  input wire logic chip_select_strap_2,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_0,
  input wire logic wp,
  output logic prog_busy
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  typedef enum {D_IDLE, D_DEV, D_AH, D_AL, D_WDATA, D_RDATA, D_BUSY} ee_dstate_type;
  ee_dstate_type state_reg, state_next;
  logic [5:0] s1_reg, s2_reg;
  logic prev_scl_reg, prev_sda_reg;
  logic scl_s, sda_s, wp_s;
  logic [2:0] cs_s;
  logic start, stop, rise, fall;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shf_reg, shf_next, ahi_reg, ahi_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [PAGE_BYTES-1:0] mask_reg, mask_next;
  logic [TW-1:0] tcnt_reg, tcnt_next;
  logic oe_reg, oe_next, rw_reg, rw_next, mack_reg, mack_next;
  logic load, pg_we, commit;
  logic [7:0] mem_reg [MEM_BYTES];
  logic [7:0] page_reg [PAGE_BYTES];

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  assign {scl_s, sda_s, cs_s, wp_s} = s2_reg;
  assign start = scl_s && prev_scl_reg && prev_sda_reg && !sda_s;
  assign stop = scl_s && prev_scl_reg && !prev_sda_reg && sda_s;
  assign rise = scl_s && !prev_scl_reg;
  assign fall = !scl_s && prev_scl_reg;
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = oe_reg;
  assign prog_busy = state_reg == D_BUSY;

  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 5'h01};
  endfunction

  // ---------------------------------------------------------------
  // protocol engine
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    bit_next = bit_reg;
    shf_next = shf_reg;
    ahi_next = ahi_reg;
    addr_next = addr_reg;
    mask_next = mask_reg;
    tcnt_next = tcnt_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    mack_next = mack_reg;
    load = 1'b0;
    pg_we = 1'b0;
    commit = 1'b0;
    if (state_reg == D_BUSY)
    begin
      // bus fully ignored here, so polling sees no ack
      if (tcnt_reg == TW'(PROG_CYCLES - 1))
      begin
        commit = 1'b1;
        state_next = D_IDLE;
      end
      else
        tcnt_next = tcnt_reg + 1'b1;
    end
    else if (start)
    begin
      state_next = D_DEV;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end
    else if (stop)
    begin
      oe_next = 1'b0;
      if (state_reg == D_WDATA && mask_reg != '0 && !wp_s)
      begin
        tcnt_next = '0;
        state_next = D_BUSY;
      end
      else
        state_next = D_IDLE;
    end
    else if (state_reg != D_IDLE)
    begin
      if (rise)
      begin
        if (bit_reg < 4'(BYTE_BITS))
        begin
          shf_next = {shf_reg[6:0], (state_reg == D_RDATA) ? 1'b0 : sda_s};
          bit_next = bit_reg + 4'h1;
        end
        else
        begin
          mack_next = !sda_s;
          bit_next = 4'(BYTE_BITS + 1);
        end
      end
      else if (fall)
      begin
        if (bit_reg < 4'(BYTE_BITS))
        begin
          if (state_reg == D_RDATA)
            oe_next = !shf_reg[7];
        end
        else if (bit_reg == 4'(BYTE_BITS))
        begin
          oe_next = state_reg != D_RDATA;
          case (state_reg)
            D_DEV:
              if (shf_reg[7:4] == TYPE_ID && shf_reg[3:1] == cs_s)
                rw_next = shf_reg[0];
              else
              begin
                oe_next = 1'b0;
                state_next = D_IDLE;
              end
            D_AH: ahi_next = shf_reg;
            D_AL:
            begin
              addr_next = {ahi_reg[ADDR_W-9:0], shf_reg};
              mask_next = '0;
            end
            D_WDATA:
            begin
              pg_we = 1'b1;
              mask_next[addr_reg[PAGE_W-1:0]] = 1'b1;
              addr_next = page_inc(addr_reg);
            end
            default: ;
          endcase
        end
        else
        begin
          oe_next = 1'b0;
          bit_next = 4'h0;
          case (state_reg)
            D_DEV:
              if (rw_reg)
                load = 1'b1;
              else
                state_next = D_AH;
            D_AH: state_next = D_AL;
            D_AL: state_next = D_WDATA;
            D_RDATA:
              if (mack_reg)
                load = 1'b1;
              else
                state_next = D_IDLE;
            default: ;
          endcase
        end
      end
    end
    if (load)
    begin
      shf_next = mem_reg[addr_reg];
      oe_next = !mem_reg[addr_reg][7];
      addr_next = addr_reg + 1'b1;
      state_next = D_RDATA;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= D_IDLE;
      s1_reg <= 6'h3F;
      s2_reg <= 6'h3F;
      prev_scl_reg <= 1'b1;
      prev_sda_reg <= 1'b1;
      bit_reg <= 4'h0;
      shf_reg <= 8'h00;
      ahi_reg <= 8'h00;
      addr_reg <= '0;
      mask_reg <= '0;
      tcnt_reg <= '0;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
    end
    else if (ce)
    begin
      s1_reg <= {link.scl, link.sda, chip_select_strap_2, chip_select_strap_1,
                 chip_select_strap_0, wp};
      s2_reg <= s1_reg;
      prev_scl_reg <= scl_s;
      prev_sda_reg <= sda_s;
      state_reg <= state_next;
      bit_reg <= bit_next;
      shf_reg <= shf_next;
      ahi_reg <= ahi_next;
      addr_reg <= addr_next;
      mask_reg <= mask_next;
      tcnt_reg <= tcnt_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      mack_reg <= mack_next;
    end
  end

  // ---------------------------------------------------------------
  // page buffer and array
  // ---------------------------------------------------------------
  // whole page lands at once; only bytes loaded this time change
  always_ff @(posedge clk)
  begin
    if (ce && pg_we)
      page_reg[addr_reg[PAGE_W-1:0]] <= shf_reg;
    if (ce && commit)
      for (int i = 0; i < PAGE_BYTES; i++)
        if (mask_reg[i])
          mem_reg[{addr_reg[ADDR_W-1:PAGE_W], 5'(i)}] <= page_reg[i];
  end
endmodule
`default_nettype wire

// >>> sim/ee_link_props.sv
// Purpose: link checks for the eeprom master and device pair
// Assumes: one clock domain, rstn async active low
// Notes: sees only the link wires and prog_busy
`default_nettype none
module ee_link_props
#(
  parameter int PROG_CYCLES = 50
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic prog_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_d_reg;
  logic [3:0] since_stop_reg;
  logic [3:0] since_stop_next;
  int busy_cnt_reg;
  int busy_cnt_next;
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  always_comb
  begin
    since_stop_next = (since_stop_reg == 4'hF) ? 4'hF : since_stop_reg + 4'h1;
    if (scl && sda && !sda_d_reg)
    begin
      since_stop_next = 4'h0;
    end
    busy_cnt_next = prog_busy ? busy_cnt_reg + 1 : 0;
  end
  // saturated after reset so a spurious busy start fails
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sda_d_reg <= 1'b1;
      since_stop_reg <= 4'hF;
      busy_cnt_reg <= 0;
    end
    else
    begin
      sda_d_reg <= sda;
      since_stop_reg <= since_stop_next;
      busy_cnt_reg <= busy_cnt_next;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence stop_seq;
    scl && $rose(sda);
  endsequence
  sequence dev_bit_seq;
    dev_sda_oe && $rose(scl);
  endsequence
  busy_quiet_a: assert property (prog_busy |-> !dev_sda_oe)
    else $error("device drove data while programming");
  busy_start_a: assert property ($rose(prog_busy) |-> since_stop_reg <= 4'h8)
    else $error("programming began without a stop");
  busy_len_a: assert property (busy_cnt_reg <= PROG_CYCLES)
    else $error("programming ran too long");
  dev_launch_a: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device pulled data while clock high");
  dev_hold_a: assert property (dev_bit_seq |-> dev_sda_oe [*4])
    else $error("device let go during clock high");
  one_driver_a: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
    else $error("both ends drive data in one bit");
  stop_release_a: assert property (stop_seq |=> !dev_sda_oe [*4])
    else $error("device drives data after stop");
  clock_high_a: assert property ($rose(scl) |-> scl [*4])
    else $error("bus clock high phase too short");
endmodule
`default_nettype wire

// >>> sim/i2c_serial_eeprom_rw_engine_tb.sv
// Purpose: end to end test of the eeprom master and device
// Assumes: programming time cut to PROG clocks
// Notes: ce dropped once with a request held, to see the master end stay idle with op_ready up
`default_nettype none
module i2c_serial_eeprom_rw_engine_tb
  import ee_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // longer than one poll, so the first poll must be refused
  localparam int PROG = 600;
  localparam logic [2:0] SEL = 3'h5;
  logic clk;
  logic rstn;
  logic ce;
  logic wp;
  logic op_valid;
  logic op_ready;
  ee_op_type op_kind;
  logic [2:0] op_sel;
  logic [ADDR_W-1:0] op_addr;
  logic [7:0] op_len;
  logic [7:0] wr_data;
  logic wr_valid;
  logic wr_ready;
  logic [7:0] rd_data;
  logic rd_valid;
  logic op_done;
  logic op_nack;
  logic prog_busy;
  logic nk;
  logic [7:0] rdq[$];
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  ee_link_if link();
  ee_host_end u_ee_host_end (.clk(clk), .rstn(rstn), .ce(ce), .link(link),
    .op_valid(op_valid), .op_ready(op_ready), .op_kind(op_kind), .op_sel(op_sel),
    .op_addr(op_addr), .op_len(op_len), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .op_done(op_done),
    .op_nack(op_nack));
  ee_dev_end #(.PROG_CYCLES(PROG)) u_ee_dev_end (.clk(clk), .rstn(rstn), .ce(ce),
    .link(link), .chip_select_strap_2(SEL[2]), .chip_select_strap_1(SEL[1]),
    .chip_select_strap_0(SEL[0]), .wp(wp), .prog_busy(prog_busy));
  ee_link_props #(.PROG_CYCLES(PROG)) u_ee_link_props (.clk(clk), .rstn(rstn),
    .scl(link.scl), .sda(link.sda), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe), .prog_busy(prog_busy));
  // ------------------------------------------------------------
  // clock, timeout and tasks
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (fails == 0 && num_checks > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask
  // leaves wr_valid up so back to back pushes never toggle it
  task automatic push(input logic [7:0] d);
    wr_data = d;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask
  task automatic run_op(input ee_op_type k, input logic [12:0] a, input logic [7:0] n,
    input logic [2:0] s = SEL);
    op_kind = k;
    op_addr = a;
    op_len = n;
    op_sel = s;
    op_valid = 1'b1;
    rdq.delete();
    nk = 1'b0;
    while (op_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1)
        rdq.push_back(rd_data);
      if (op_nack === 1'b1)
        nk = 1'b1;
    end
    while (op_done !== 1'b1);
  endtask
  task automatic wr(input logic [12:0] a, input int n, input logic [7:0] base);
    for (int i = 0; i < n && i < 32; i++)
      push(base + 8'(i));
    wr_valid = 1'b0;
    if (n > 32)
      chk("fifo full", {7'h00, wr_ready}, 8'h00);
    fork
      run_op(OP_WRITE, a, 8'(n));
      begin
        @(posedge clk);
        #1;
        for (int i = 32; i < n; i++)
          push(base + 8'(i));
        wr_valid = 1'b0;
      end
    join
    chk("write nack", {7'h00, nk}, 8'h00);
  endtask
  // busy is up three clocks after the stop, op_done four
  task automatic settle(input logic first);
    chk("busy at stop", {7'h00, prog_busy}, {7'h00, first});
    run_op(OP_POLL, 13'h0000, 8'h00);
    chk("first poll", {7'h00, nk}, {7'h00, first});
    for (int i = 0; i < 20 && nk === 1'b1; i++)
      run_op(OP_POLL, 13'h0000, 8'h00);
    chk("last poll", {7'h00, nk}, 8'h00);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    wp = 1'b0;
    op_valid = 1'b0;
    op_kind = OP_WRITE;
    op_sel = SEL;
    op_addr = 13'h0000;
    op_len = 8'h00;
    wr_data = 8'h00;
    wr_valid = 1'b0;
    nk = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    run_op(OP_POLL, 13'h0000, 8'h00, 3'h2);
    chk("wrong select", {7'h00, nk}, 8'h01);
    // a request held while ce is low must not be taken
    ce = 1'b0;
    op_kind = OP_POLL;
    op_valid = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("frozen ready", {7'h00, op_ready}, 8'h01);
    op_valid = 1'b0;
    ce = 1'b1;
    wr(13'h0105, 34, 8'h10);
    settle(1'b1);
    run_op(OP_RAND_READ, 13'h0105, 8'h1A);
    chk("read count", 8'(rdq.size()), 8'h1A);
    foreach (rdq[i])
      chk("page byte", rdq[i], (i < 2) ? 8'h30 + 8'(i) : 8'h10 + 8'(i));
    run_op(OP_CUR_READ, 13'h0000, 8'h01);
    chk("current byte", rdq[0], 8'h2A);
    wr(13'h1FFF, 1, 8'hA5);
    settle(1'b1);
    wr(13'h0000, 1, 8'hC3);
    settle(1'b1);
    run_op(OP_RAND_READ, 13'h1FFF, 8'h02);
    chk("top byte", rdq[0], 8'hA5);
    chk("wrapped byte", rdq[1], 8'hC3);
    wp = 1'b1;
    wr(13'h0105, 1, 8'hEE);
    settle(1'b0);
    run_op(OP_RAND_READ, 13'h0105, 8'h01);
    chk("protected byte", rdq[0], 8'h30);
    end_sim();
  end
endmodule
`default_nettype wire
